// ### common/pmc_map.svh
/*
 * Constants of the power mode controller: clock source codes, wake
 * source bit positions, field widths and timing counts.
 * Assumes the system clock runs at 10 MHz.
 */
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_CLK_PERIOD_NS 100
`define PMC_IRC_FREQ_KHZ  12000

// clock source select codes
`define PMC_SRC_W      3
`define PMC_SRC_IRC    3'h0
`define PMC_SRC_LPOSC  3'h1
`define PMC_SRC_CLKIN  3'h2
`define PMC_SRC_RTC32K 3'h3
`define PMC_SRC_PLL    3'h4

// wake source bit positions
`define PMC_WAKE_W  6
`define PMC_WK_PIN  0
`define PMC_WK_RTC  1
`define PMC_WK_UTK  2
`define PMC_WK_WDT  3
`define PMC_WK_BOD  4
`define PMC_WK_SER  5

`define PMC_PERIPH_W  8
`define PMC_WDT_CFG_W 8
`define PMC_CNT_W     8

// settle times in ns, least times so rounded up to cycles
`define PMC_WAKE_DS_NS 2000
`define PMC_WAKE_PD_NS 10000
`define PMC_PRST_NS    500
`define PMC_WAKE_DS_CYC \
  ((`PMC_WAKE_DS_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_WAKE_PD_CYC \
  ((`PMC_WAKE_PD_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_PRST_CYC \
  ((`PMC_PRST_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)

`define PMC_BOOT_ADDR 32'h0000_0000
`define PMC_SWD_RST   1'h1

`endif

// ### common/pmc_pkg.sv
/*
 * Types of the power mode controller: modes, states and the packed
 * state records of the delay counter and the controller.
 * Assumes pmc_map.svh is on the include path.
 */
`include "pmc_map.svh"

package pmc_pkg;

  typedef enum logic [1:0] {
    PMC_MD_SLEEP  = 2'b00,
    PMC_MD_DSLEEP = 2'b01,
    PMC_MD_PDOWN  = 2'b10,
    PMC_MD_DPD    = 2'b11
  } pmc_mode_t;

  typedef enum logic [2:0] {
    PMC_RUN    = 3'b000,
    PMC_SLEEP  = 3'b001,
    PMC_DSLEEP = 3'b010,
    PMC_PDOWN  = 3'b011,
    PMC_DPD    = 3'b100,
    PMC_WAKE   = 3'b101,
    PMC_PRST   = 3'b110,
    PMC_BOOT   = 3'b111
  } pmc_state_t;

  typedef struct packed {
    logic [`PMC_CNT_W-1:0] cnt;
    logic                  busy;
  } pmc_cnt_st_t;

  typedef struct packed {
    pmc_state_t                state;
    logic [`PMC_SRC_W-1:0]     clk_src;
    logic                      pll_en;
    logic                      bod_flag;
    logic                      bod_irq;
    logic                      chip_rst;
    logic                      wdt_lock;
    logic [`PMC_WDT_CFG_W-1:0] wdt_cfg;
    logic                      wdt_rej;
    logic                      swd_sel;
    logic                      strap_done;
    logic                      in_system_programming;
    logic                      boot_start;
    logic                      dbg_halt;
  } pmc_ctrl_st_t;

endpackage

// ### core/pmc_wake_qual.sv
/*
 * Wake source qualifier: a source counts only when enabled in both
 * the system configuration unit and the processor interrupt controller.
 * Assumes sources are levels synchronous to the system clock.
 */
`timescale 1ns/10ps
`include "pmc_map.svh"

module pmc_wake_qual
  import pmc_pkg::*;
#(
  parameter int W = `PMC_WAKE_W
) (
  input  wire logic [W-1:0] src_i,     // raw wake requests
  input  wire logic [W-1:0] sys_en_i,  // system config wake enables
  input  wire logic [W-1:0] irq_en_i,  // interrupt controller enables
  output logic              any_o      // some qualified source active
);

  assign any_o = |(src_i & sys_en_i & irq_en_i); // R9

endmodule // pmc_wake_qual

// ### core/pmc_delay_cnt.sv
/*
 * One-shot down counter: busy for load_i cycles after start_i,
 * done_o marks the last busy cycle.
 * Assumes load_i is at least one.
 */
`timescale 1ns/10ps
`include "pmc_map.svh"

module pmc_delay_cnt
  import pmc_pkg::*;
(
  input  wire logic                  sys_clk_i, // system clock
  input  wire logic                  nrst_i,    // async reset, low
  input  wire logic                  start_i,   // start pulse
  input  wire logic [`PMC_CNT_W-1:0] load_i,    // cycles to count
  output logic                       busy_o,    // counting
  output logic                       done_o     // last cycle pulse
);

  pmc_cnt_st_t st_r;
  pmc_cnt_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start_i) begin
      st_nxt.cnt  = load_i;
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      st_nxt.cnt  = st_r.cnt - `PMC_CNT_W'(1);
      st_nxt.busy = (st_r.cnt != `PMC_CNT_W'(1));
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
  assign done_o = st_r.busy && (st_r.cnt == `PMC_CNT_W'(1));

endmodule // pmc_delay_cnt

// ### core/pmc_ctrl.sv
/*
 * Power mode controller: clock source and PLL enable, the four low
 * power modes, wake-up, brownout flag and reset, watchdog lock,
 * debug system reset, debug pin default and programming entry strap.
 * Assumes all inputs are synchronous to sys_clk_i and that nrst_i
 * is the chip reset, also driven by the reset pin.
 */
// Behaviour
// (R1) reset selects internal RC oscillator as clock
// (R2) software enables and disables the PLL
// (R3) sleep gates core and unused peripheral clocks
// (R4) sleep resumes on interrupt or reset
// (R5) low power modes retain state, hold pins; retain_o, pin_hold_o stay low in deep power-down
// (R6) deep-sleep stops clocks except optional 32k, lposc
// (R7) deep-sleep wakes on listed event set
// (R8) serial wake sources configured as slaves
// (R9) wake needs system and controller enable
// (R10) power-down stops clocks, flash, analog; brownout optional
// (R11) power-down wakes on same set, slower
// (R12) deep power-down wakes by reset or RTC
// (R13) brownout flag, interrupt and reset thresholds
// (R14) enabled watchdog configuration locked until reset
// (R15) debug reset: peripherals, boot, address zero, halt
// (R16) debug pins default to serial wire debug
// (R17) low programming pin at reset enters programming
// (R18) wake restores clocks before releasing processor
`timescale 1ns/10ps
`include "pmc_map.svh"

module pmc_ctrl
  import pmc_pkg::*;
(
  input  wire logic                     sys_clk_i,     // 10 MHz clock
  input  wire logic                     nrst_i,        // async reset
  input  wire logic                     clk_sel_wr_i,  // clock sel write
  input  wire logic [`PMC_SRC_W-1:0]    clk_sel_i,     // clock sel data
  input  wire logic                     pll_wr_i,      // pll enable write
  input  wire logic                     pll_en_i,      // pll enable data
  input  wire logic                     sleep_enter_i, // core waits
  input  wire logic [1:0]               mode_sel_i,    // pmc_mode_t
  input  wire logic                     irq_pend_i,    // any core irq
  input  wire logic [`PMC_PERIPH_W-1:0] periph_use_i,  // in use in sleep
  input  wire logic                     keep_32k_i,    // keep 32k clock
  input  wire logic                     keep_lposc_i,  // keep lp osc
  input  wire logic                     keep_bod_i,    // keep brownout
  input  wire logic [`PMC_WAKE_W-1:0]   wake_src_i,    // wake requests
  input  wire logic [`PMC_WAKE_W-1:0]   wake_en_i,     // sys wake enable
  input  wire logic [`PMC_WAKE_W-1:0]   irq_en_i,      // ctrl irq enable
  input  wire logic                     supply_low_i,  // fixed level trip
  input  wire logic                     bod_clr_i,     // clear flag
  input  wire logic                     bod_irq_en_i,  // flag irq enable
  input  wire logic                     bod_thr_i,     // selected level
  input  wire logic                     bod_thr_irq_i, // thr irq enable
  input  wire logic                     bod_rst_en_i,  // thr reset enable
  input  wire logic                     wdt_wr_i,      // wdt config write
  input  wire logic [`PMC_WDT_CFG_W-1:0] wdt_cfg_i,    // wdt config data
  input  wire logic                     wdt_en_set_i,  // enable with write
  input  wire logic                     dbg_debug_system_reset_request_i,  // debug reset req
  input  wire logic                     boot_done_i,   // boot code done
  input  wire logic                     dbg_halted_i,  // core halted
  input  wire logic                     pin_mux_wr_i,  // debug pin write
  input  wire logic                     pin_mux_swd_i, // 1: debug func
  input  wire logic                     isp_entry_n_i, // programming pin
  input  wire logic                     isp_samp_dis_i,// sampling off
  output logic [`PMC_SRC_W-1:0]         clk_src_o,     // clock source
  output logic                          pll_en_o,      // pll running
  output logic                          core_clk_en_o, // core clock
  output logic                          cpu_run_o,     // core released
  output logic [`PMC_PERIPH_W-1:0]      periph_clk_en_o, // periph clocks
  output logic                          clk_src_en_o,  // main sources on
  output logic                          osc32k_en_o,   // 32 kHz clock
  output logic                          lposc_en_o,    // low power osc
  output logic                          analog_en_o,   // analog blocks
  output logic                          flash_stby_o,  // flash standby
  output logic                          flash_off_o,   // flash off
  output logic                          bod_en_o,      // brownout on
  output logic                          retain_o,      // hold contents
  output logic                          pin_hold_o,    // pins static
  output logic                          dpd_off_o,     // main power off
  output logic                          bod_flag_o,    // brownout flag
  output logic                          bod_irq_o,     // brownout irq
  output logic                          chip_rst_o,    // chip reset req
  output logic                          wdt_lock_o,    // watchdog locked
  output logic [`PMC_WDT_CFG_W-1:0]     wdt_cfg_o,     // wdt config
  output logic                          wdt_rej_o,     // write refused
  output logic                          periph_rst_o,  // periph reset
  output logic                          boot_start_o,  // run boot code
  output logic [31:0]                   restart_addr_o,// restart address
  output logic                          dbg_halt_o,    // halt at entry
  output logic                          swd_sel_o,     // debug pin func
  output logic                          isp_mode_o     // programming
);

  // ****************************************
  // wake qualification and counters
  // ****************************************
  pmc_ctrl_st_t            st_r;
  pmc_ctrl_st_t            st_nxt;
  logic                    wake_any;
  logic                    rtc_wake;
  logic                    wcnt_start;
  logic [`PMC_CNT_W-1:0]   wcnt_load;
  logic                    wcnt_done;
  logic                    pcnt_start;
  logic                    pcnt_done;
  logic                    deep;

  pmc_wake_qual #(
    .W (`PMC_WAKE_W)
  ) u_wake_qual (
    .src_i    (wake_src_i),
    .sys_en_i (wake_en_i),
    .irq_en_i (irq_en_i),
    .any_o    (wake_any)
  );

  // controller is unpowered in deep power-down, only the system enable
  assign rtc_wake = wake_src_i[`PMC_WK_RTC] & wake_en_i[`PMC_WK_RTC];

  pmc_delay_cnt u_wake_cnt (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .start_i   (wcnt_start),
    .load_i    (wcnt_load),
    .busy_o    (),
    .done_o    (wcnt_done)
  );

  pmc_delay_cnt u_prst_cnt (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .start_i   (pcnt_start),
    .load_i    (`PMC_CNT_W'(`PMC_PRST_CYC)),
    .busy_o    (),
    .done_o    (pcnt_done)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.boot_start = 1'b0;
    st_nxt.wdt_rej    = 1'b0;
    wcnt_start = 1'b0;
    wcnt_load  = `PMC_CNT_W'(`PMC_WAKE_DS_CYC);
    pcnt_start = 1'b0;
    // strap caught once, on the first edge after release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.in_system_programming = !isp_entry_n_i && !isp_samp_dis_i; // R17
    end
    if (clk_sel_wr_i && (clk_sel_i <= `PMC_SRC_PLL)) begin
      st_nxt.clk_src = clk_sel_i; // R1
    end
    if (pll_wr_i) begin
      st_nxt.pll_en = pll_en_i; // R2
    end
    if (pin_mux_wr_i) begin
      st_nxt.swd_sel = pin_mux_swd_i;
    end
    // set wins over clear
    st_nxt.bod_flag = supply_low_i | (st_r.bod_flag & ~bod_clr_i); // R13
    st_nxt.bod_irq  = (st_r.bod_flag & bod_irq_en_i)
                    | (bod_thr_i & bod_thr_irq_i); // R13
    st_nxt.chip_rst = st_r.chip_rst | (bod_thr_i & bod_rst_en_i); // R13
    if (wdt_wr_i) begin
      if (st_r.wdt_lock) begin
        st_nxt.wdt_rej = 1'b1; // R14
      end else begin
        st_nxt.wdt_cfg  = wdt_cfg_i;
        st_nxt.wdt_lock = wdt_en_set_i; // R14
      end
    end
    if (dbg_halted_i) begin
      st_nxt.dbg_halt = 1'b0;
    end
    case (st_r.state)
      PMC_RUN: begin
        if (dbg_debug_system_reset_request_i) begin
          st_nxt.state = PMC_PRST; // R15
          pcnt_start   = 1'b1;
        end else if (sleep_enter_i) begin
          case (pmc_mode_t'(mode_sel_i))
            PMC_MD_SLEEP:  st_nxt.state = PMC_SLEEP;
            PMC_MD_DSLEEP: st_nxt.state = PMC_DSLEEP;
            PMC_MD_PDOWN:  st_nxt.state = PMC_PDOWN;
            PMC_MD_DPD:    st_nxt.state = PMC_DPD;
            default:       st_nxt.state = PMC_RUN;
          endcase
        end
      end
      PMC_SLEEP: begin
        // clocks never stopped, so only the core and unused peripheral clocks come back
        if (irq_pend_i) begin
          st_nxt.state = PMC_RUN; // R4
        end
      end
      PMC_DSLEEP: begin
        if (wake_any) begin
          st_nxt.state = PMC_WAKE; // R7
          wcnt_start   = 1'b1;
        end
      end
      PMC_PDOWN: begin
        if (wake_any) begin
          st_nxt.state = PMC_WAKE; // R11
          wcnt_start   = 1'b1;
          wcnt_load    = `PMC_CNT_W'(`PMC_WAKE_PD_CYC); // R11
        end
      end
      PMC_DPD: begin
        // only a full chip reset leaves this state
        if (rtc_wake) begin
          st_nxt.chip_rst = 1'b1; // R12
        end
      end
      PMC_WAKE: begin
        if (wcnt_done) begin
          st_nxt.state = PMC_RUN; // R18
        end
      end
      PMC_PRST: begin
        if (pcnt_done) begin
          st_nxt.state      = PMC_BOOT;
          st_nxt.boot_start = 1'b1; // R15
        end
      end
      PMC_BOOT: begin
        if (boot_done_i) begin
          st_nxt.state    = PMC_RUN;
          st_nxt.dbg_halt = 1'b1; // R15
        end
      end
      default: st_nxt.state = PMC_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r         <= '0;
      st_r.clk_src <= `PMC_SRC_IRC; // R1
      st_r.swd_sel <= `PMC_SWD_RST; // R16
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign deep = (st_r.state == PMC_DSLEEP) || (st_r.state == PMC_PDOWN);

  assign clk_src_o     = st_r.clk_src;
  assign clk_src_en_o  = !deep && (st_r.state != PMC_DPD); // R6 R10
  assign pll_en_o      = st_r.pll_en && clk_src_en_o; // R2
  assign core_clk_en_o = (st_r.state == PMC_RUN) || (st_r.state == PMC_WAKE)
                      || (st_r.state == PMC_PRST)
                      || (st_r.state == PMC_BOOT); // R3 R18
  assign cpu_run_o     = (st_r.state == PMC_RUN)
                      || (st_r.state == PMC_BOOT); // R18
  assign periph_clk_en_o = (st_r.state == PMC_SLEEP) ? periph_use_i :
                           clk_src_en_o ? {`PMC_PERIPH_W{1'b1}} :
                           {`PMC_PERIPH_W{1'b0}}; // R3 R6
  // 32 kHz lives in the always-on domain through deep power-down
  assign osc32k_en_o   = deep ? keep_32k_i : 1'b1; // R6 R10
  assign lposc_en_o    = deep ? keep_lposc_i : clk_src_en_o; // R6
  assign analog_en_o   = clk_src_en_o; // R6 R10
  assign flash_stby_o  = (st_r.state == PMC_DSLEEP); // R6
  assign flash_off_o   = (st_r.state == PMC_PDOWN)
                      || (st_r.state == PMC_DPD); // R10
  assign bod_en_o      = deep ? keep_bod_i : clk_src_en_o; // R10
  assign retain_o      = deep || (st_r.state == PMC_SLEEP); // R5
  assign pin_hold_o    = retain_o; // R5
  assign dpd_off_o     = (st_r.state == PMC_DPD); // R12
  assign bod_flag_o    = st_r.bod_flag;
  assign bod_irq_o     = st_r.bod_irq;
  assign chip_rst_o    = st_r.chip_rst;
  assign wdt_lock_o    = st_r.wdt_lock;
  assign wdt_cfg_o     = st_r.wdt_cfg;
  assign wdt_rej_o     = st_r.wdt_rej;
  assign periph_rst_o  = (st_r.state == PMC_PRST); // R15
  assign boot_start_o  = st_r.boot_start;
  assign restart_addr_o = `PMC_BOOT_ADDR; // R15
  assign dbg_halt_o    = st_r.dbg_halt;
  assign swd_sel_o     = st_r.swd_sel; // R16
  assign isp_mode_o    = st_r.in_system_programming;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_clk_src_hold: assert property ( // R1
    !clk_sel_wr_i |=> $stable(clk_src_o))
    else $error("clock source moved without a write");
  a_pll_sw_en: assert property ( // R2
    pll_wr_i && pll_en_i && st_r.state == PMC_RUN && !sleep_enter_i
      |=> pll_en_o)
    else $error("pll not enabled after write");
  a_sleep_gate: assert property ( // R3
    st_r.state == PMC_SLEEP |-> !core_clk_en_o
      && periph_clk_en_o == periph_use_i)
    else $error("sleep clocks not gated");
  a_sleep_resume: assert property ( // R4
    st_r.state == PMC_SLEEP && irq_pend_i |=> cpu_run_o && core_clk_en_o)
    else $error("sleep did not resume on interrupt");
  a_retain_hold: assert property ( // R5
    st_r.state inside {PMC_SLEEP, PMC_DSLEEP, PMC_PDOWN}
      |-> pin_hold_o && retain_o)
    else $error("state not retained in low power mode");
  a_dsleep_off: assert property ( // R6
    st_r.state == PMC_DSLEEP |-> !clk_src_en_o && !analog_en_o
      && flash_stby_o && periph_clk_en_o == '0)
    else $error("deep-sleep clocks not off");
  a_dsleep_wake: assert property ( // R7
    st_r.state == PMC_DSLEEP && wake_any |=> ##[20:24] cpu_run_o)
    else $error("deep-sleep wake too slow");
  a_wake_gated: assert property ( // R9
    st_r.state == PMC_DSLEEP && !wake_any |=> st_r.state == PMC_DSLEEP)
    else $error("woke without enabled source");
  a_pdown_off: assert property ( // R10
    st_r.state == PMC_PDOWN |-> flash_off_o && !clk_src_en_o
      && !analog_en_o && bod_en_o == keep_bod_i)
    else $error("power-down not shut down");
  a_pdown_wake: assert property ( // R11
    st_r.state == PMC_PDOWN && wake_any |=> ##[100:104] cpu_run_o)
    else $error("power-down wake out of time");
  a_dpd_rtc: assert property ( // R12
    st_r.state == PMC_DPD && rtc_wake |=> chip_rst_o && dpd_off_o)
    else $error("rtc did not wake deep power-down");
  a_bod_flag: assert property ( // R13
    supply_low_i |=> bod_flag_o)
    else $error("brownout flag lost");
  a_wdt_locked: assert property ( // R14
    wdt_lock_o && wdt_wr_i |=> $stable(wdt_cfg_o) && wdt_lock_o
      && wdt_rej_o)
    else $error("locked watchdog modified");
  a_debug_system_reset_request_seq: assert property ( // R15
    st_r.state == PMC_RUN && dbg_debug_system_reset_request_i
      |=> periph_rst_o [*5] ##1 boot_start_o && restart_addr_o == '0)
    else $error("debug reset sequence wrong");
  a_swd_hold: assert property ( // R16
    !pin_mux_wr_i |=> $stable(swd_sel_o))
    else $error("debug pin function moved");
  a_isp_strap: assert property ( // R17
    $rose(st_r.strap_done) |-> isp_mode_o ==
      (!$past(isp_entry_n_i) && !$past(isp_samp_dis_i)))
    else $error("programming strap wrong");
  a_wake_order: assert property ( // R18
    st_r.state == PMC_WAKE
      |-> !cpu_run_o && core_clk_en_o && clk_src_en_o && lposc_en_o)
    else $error("released before clocks restored");

endmodule // pmc_ctrl

// ### tb/pmc_wake_agent.sv
/* Model of the wake event sources that sit around the controller.
   Assumes one system clock and that the core runs when cpu_run_i. */
`timescale 1ns/10ps
module pmc_wake_agent #(
  parameter int W = 6
) (
  input  wire logic         sys_clk_i,  // system clock
  input  wire logic         nrst_i,     // async reset, low
  input  wire logic [W-1:0] fire_i,     // event strobes
  input  wire logic         cpu_run_i,  // core executing
  output logic      [W-1:0] wake_src_o  // pending wake levels
);
  logic run_q_r;
  // serial sources fire whenever strobed, with no slave setup modelled
  // requests stand until the core runs again, as unserviced peripherals do
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_src_o <= '0;
      run_q_r    <= 1'b1;
    end else begin
      run_q_r <= cpu_run_i;
      if (cpu_run_i && !run_q_r) wake_src_o <= fire_i;
      else wake_src_o <= wake_src_o | fire_i;
    end
  end
endmodule // pmc_wake_agent

// ### tb/pmc_ctrl_tb_top.sv
/* Self-checking bench of the power mode controller.
   Assumes pmc_map.svh on the include path and pmc_pkg compiled. */
`timescale 1ns/10ps
`include "pmc_map.svh"
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  $display("ERROR %s exp %0h got %0h", nm, e, a); bad_count++; end end
module pmc_ctrl_tb_top;
  import pmc_pkg::*;
  logic sys_clk_i, nrst_i, clk_sel_wr_i, pll_wr_i, pll_en_i, sleep_enter_i;
  logic irq_pend_i, keep_32k_i, keep_lposc_i, keep_bod_i, supply_low_i;
  logic bod_clr_i, bod_irq_en_i, bod_thr_i, bod_thr_irq_i, bod_rst_en_i;
  logic wdt_wr_i, wdt_en_set_i, dbg_debug_system_reset_request_i, boot_done_i, dbg_halted_i;
  logic pin_mux_wr_i, pin_mux_swd_i, isp_entry_n_i, isp_samp_dis_i;
  logic [2:0] clk_sel_i, clk_src_o;
  logic [1:0] mode_sel_i;
  logic [7:0] periph_use_i, wdt_cfg_i, periph_clk_en_o, wdt_cfg_o;
  logic [5:0] wake_src_i, wake_en_i, irq_en_i, fire;
  logic pll_en_o, core_clk_en_o, cpu_run_o, clk_src_en_o, osc32k_en_o;
  logic lposc_en_o, analog_en_o, flash_stby_o, flash_off_o, bod_en_o;
  logic retain_o, pin_hold_o, dpd_off_o, bod_flag_o, bod_irq_o, chip_rst_o;
  logic wdt_lock_o, wdt_rej_o, periph_rst_o, boot_start_o, dbg_halt_o;
  logic swd_sel_o, isp_mode_o;
  logic [31:0] restart_addr_o;
  int bad_count, n_compared;

  pmc_ctrl dut (.*);
  pmc_wake_agent #(.W(6)) agent (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .fire_i(fire), .cpu_run_i(cpu_run_o), .wake_src_o(wake_src_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic rst(logic isp_n);
    isp_entry_n_i = isp_n;
    nrst_i = 1'b0;
    tick(6);
    nrst_i = 1'b1;
    tick(2);
    isp_entry_n_i = 1'b1;
    `CHK("clk_src", 3'h0, clk_src_o)
    `CHK("swd_sel", 1'b1, swd_sel_o)
    `CHK("isp_mode", ~isp_n & ~isp_samp_dis_i, isp_mode_o)
  endtask
  task automatic t_clk();
    clk_sel_wr_i = 1'b1;
    clk_sel_i = `PMC_SRC_PLL;
    tick();
    clk_sel_i = 3'h5;
    tick();
    clk_sel_wr_i = 1'b0;
    `CHK("clk_src", `PMC_SRC_PLL, clk_src_o)
    pll_wr_i = 1'b1;
    for (int i = 1; i >= 0; i--) begin
      pll_en_i = i[0];
      tick();
      `CHK("pll_en", i[0], pll_en_o)
    end
    pll_wr_i = 1'b0;
    pin_mux_wr_i = 1'b1;
    tick();
    pin_mux_wr_i = 1'b0;
    `CHK("swd_sel", 1'b0, swd_sel_o)
  endtask
  task automatic t_wdt();
    wdt_wr_i = 1'b1;
    wdt_en_set_i = 1'b1;
    wdt_cfg_i = 8'h3C;
    tick();
    `CHK("wdt_lock", 1'b1, wdt_lock_o)
    wdt_cfg_i = 8'hC3;
    tick();
    wdt_wr_i = 1'b0;
    `CHK("wdt_rej", 1'b1, wdt_rej_o)
    tick();
    `CHK("wdt_cfg", 8'h3C, wdt_cfg_o)
    `CHK("wdt_rej", 1'b0, wdt_rej_o)
  endtask
  task automatic t_sleep();
    periph_use_i = 8'hA5;
    sleep_enter_i = 1'b1;
    mode_sel_i = 2'b00;
    tick();
    sleep_enter_i = 1'b0;
    `CHK("core_clk", 1'b0, core_clk_en_o)
    `CHK("periph_clk", 8'hA5, periph_clk_en_o)
    `CHK("pin_hold", 1'b1, pin_hold_o)
    tick(3);
    `CHK("cpu_run", 1'b0, cpu_run_o)
    irq_pend_i = 1'b1;
    tick();
    irq_pend_i = 1'b0;
    `CHK("cpu_run", 1'b1, cpu_run_o)
  endtask
  // m: 1 deep-sleep, 2 power-down; exp_n edges from wake to release
  task automatic t_lp(logic [1:0] m, int exp_n);
    int n;
    sleep_enter_i = 1'b1;
    mode_sel_i = m;
    tick();
    sleep_enter_i = 1'b0;
    `CHK("src_en", 1'b0, clk_src_en_o)
    `CHK("flash_stby", m == 2'b01, flash_stby_o)
    `CHK("flash_off", m == 2'b10, flash_off_o)
    `CHK("osc32k", keep_32k_i, osc32k_en_o)
    `CHK("bod_en", keep_bod_i, bod_en_o)
    `CHK("retain", 1'b1, retain_o)
    `CHK("lposc", keep_lposc_i, lposc_en_o)
    `CHK("analog", 1'b0, analog_en_o)
    fire = 6'h01 << `PMC_WK_SER;
    irq_en_i = 6'h00;
    tick();
    fire = 6'h00;
    tick(5);
    `CHK("cpu_run", 1'b0, cpu_run_o)
    irq_en_i = 6'h3F;
    n = 0;
    do begin
      tick();
      n++;
      if (n == 1) `CHK("wake_clk", 1'b1, clk_src_en_o)
    end while (cpu_run_o !== 1'b1 && n < 200);
    `CHK("wake_cyc", exp_n, n)
    `CHK("core_clk", 1'b1, core_clk_en_o)
  endtask
  task automatic t_dbg();
    dbg_debug_system_reset_request_i = 1'b1;
    tick();
    dbg_debug_system_reset_request_i = 1'b0;
    tick(4);
    `CHK("periph_rst", 1'b1, periph_rst_o)
    tick();
    `CHK("boot_start", 1'b1, boot_start_o)
    `CHK("restart", `PMC_BOOT_ADDR, restart_addr_o)
    boot_done_i = 1'b1;
    tick();
    boot_done_i = 1'b0;
    `CHK("dbg_halt", 1'b1, dbg_halt_o)
    dbg_halted_i = 1'b1;
    tick();
    dbg_halted_i = 1'b0;
    `CHK("dbg_halt", 1'b0, dbg_halt_o)
  endtask
  task automatic t_bod();
    supply_low_i = 1'b1;
    bod_irq_en_i = 1'b1;
    tick();
    supply_low_i = 1'b0;
    `CHK("bod_flag", 1'b1, bod_flag_o)
    tick();
    `CHK("bod_irq", 1'b1, bod_irq_o)
    bod_clr_i = 1'b1;
    tick();
    bod_clr_i = 1'b0;
    `CHK("bod_flag", 1'b0, bod_flag_o)
    bod_thr_i = 1'b1;
    bod_thr_irq_i = 1'b1;
    bod_rst_en_i = 1'b1;
    tick();
    bod_thr_i = 1'b0;
    bod_thr_irq_i = 1'b0;
    `CHK("bod_irq", 1'b1, bod_irq_o)
    `CHK("chip_rst", 1'b1, chip_rst_o)
  endtask
  task automatic t_dpd();
    sleep_enter_i = 1'b1;
    mode_sel_i = 2'b11;
    irq_en_i = 6'h00;
    tick();
    sleep_enter_i = 1'b0;
    `CHK("dpd_off", 1'b1, dpd_off_o)
    fire = 6'h01 << `PMC_WK_RTC;
    tick();
    fire = 6'h00;
    tick();
    `CHK("chip_rst", 1'b1, chip_rst_o)
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    {clk_sel_wr_i, pll_wr_i, pll_en_i, sleep_enter_i, irq_pend_i} = '0;
    {supply_low_i, bod_clr_i, bod_irq_en_i, bod_thr_i, bod_thr_irq_i} = '0;
    {bod_rst_en_i, wdt_wr_i, wdt_en_set_i, dbg_debug_system_reset_request_i} = '0;
    {boot_done_i, dbg_halted_i, pin_mux_wr_i, pin_mux_swd_i} = '0;
    {keep_32k_i, keep_lposc_i, keep_bod_i, isp_samp_dis_i} = 4'b1010;
    {clk_sel_i, mode_sel_i, periph_use_i, wdt_cfg_i, fire} = '0;
    wake_en_i = 6'h3F;
    irq_en_i = 6'h3F;
    bad_count = 0;
    n_compared = 0;
    rst(1'b1);
    t_clk();
    t_wdt();
    t_sleep();
    t_lp(2'b01, `PMC_WAKE_DS_CYC + 1);
    t_lp(2'b10, `PMC_WAKE_PD_CYC + 1);
    t_dbg();
    t_bod();
    rst(1'b1);
    t_dpd();
    rst(1'b0);
    isp_samp_dis_i = 1'b1;
    rst(1'b0);
    report_and_stop();
  end
  // whole run is some 200 cycles; hang cut at twenty times that
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
endmodule // pmc_ctrl_tb_top
